//--- include/abx_pkg.sv
package abx_pkg;
   // Register byte offsets
   localparam logic [11:0] A_MODE   = 12'h000;
   localparam logic [11:0] A_AXC    = 12'h004;
   localparam logic [11:0] A_IVL    = 12'h008;
   localparam logic [11:0] A_PTR    = 12'h00c;
   localparam logic [11:0] A_SHIFT  = 12'h010;
   localparam logic [11:0] A_STS    = 12'h014;
   localparam logic [11:0] A_MSK    = 12'h018;
   localparam logic [11:0] A_BUF    = 12'h100;
   // Field positions
   localparam int MODE_EN_BIT  = 7;
   localparam int MODE_SLV_BIT = 0;
   localparam int AXC_RE_BIT   = 7;
   localparam int AXC_RLD_BIT  = 6;
   localparam int AXC_TRF_BIT  = 3;
   localparam int IVL_SEL_BIT  = 7;
   localparam int STS_END_BIT  = 0;
   localparam int STS_HLT_BIT  = 1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_IVL  = 5'h00;
   // Cycle and period counts
   localparam int         SCK_HALF_CYC = 4;
   localparam logic [4:0] MIN_GAP_PER  = 5'h02;
   localparam logic [4:0] TAIL_PER     = 5'h02;
   // Transfer sequencer states
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_LOAD  = 3'b001,
      S_SHIFT = 3'b010,
      S_GAP   = 3'b011,
      S_TAIL  = 3'b100
   } abx_state_type;
endpackage

//--- include/abx_shift_if.sv
`timescale 1ns/10ps
interface abx_shift_if;
   logic       load;
   logic       abort;
   logic       rise;
   logic       fall;
   logic       si;
   logic       so;
   logic       done;
   logic [7:0] din;
   logic [7:0] rx;
   modport ctl (output load, abort, rise, fall, si, din, input so, done, rx);
   modport shf (input load, abort, rise, fall, si, din, output so, done, rx);
endinterface

//--- logic/abx_clkdiv.sv
`timescale 1ns/10ps
module abx_clkdiv #(
   parameter int HALF = 4
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run,
   output logic      half
);
   logic [7:0] cnt_r;

   // Half period enable of the serial clock, phase restarts on run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 8'h00;
         half  <= 1'b0;
      end else if (!run) begin
         cnt_r <= 8'h00;
         half  <= 1'b0;
      end else if (cnt_r == 8'(HALF - 1)) begin
         cnt_r <= 8'h00;
         half  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         half  <= 1'b0;
      end
   end
endmodule

//--- logic/abx_shifter.sv
`timescale 1ns/10ps
module abx_shifter (
   input  wire logic hclk,
   input  wire logic hresetn,
   abx_shift_if.shf  sif
);
   logic [7:0] sr_r;
   logic [2:0] cnt_r;
   logic       busy_r;

   // Byte shifter, msb first, out on falling and in on rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_r     <= 8'h00;
         cnt_r    <= 3'h0;
         busy_r   <= 1'b0;
         sif.so   <= 1'b0;
         sif.done <= 1'b0;
         sif.rx   <= 8'h00;
      end else begin
         sif.done <= 1'b0;
         if (sif.abort) begin
            busy_r <= 1'b0; // [R10]
            cnt_r  <= 3'h0;
         end else if (sif.load) begin
            sr_r   <= sif.din;
            sif.so <= sif.din[7];
            cnt_r  <= 3'h0;
            busy_r <= 1'b1;
         end else if (busy_r && sif.rise) begin
            sr_r  <= {sr_r[6:0], sif.si};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
               busy_r   <= 1'b0;
               sif.done <= 1'b1;
               sif.rx   <= {sr_r[6:0], sif.si};
            end
         end else if (busy_r && sif.fall) begin
            sif.so <= sr_r[7];
         end
      end
   end
endmodule

//--- logic/abx_top.sv
// Function
// [R1] Write to shift register starts when enabled
// [R2] Repeat mode: no interrupt, reload pointer, resend
// [R3] Repeat mode when reload set, receive clear
// [R4] Trigger value dropped; first buffer byte sent
// [R5] After each byte decrement pointer, load next
// [R6] Data input left to port unless receiving
// [R7] Clearing enable pauses only after byte
// [R8] Suspend clears active flag, pins to port
// [R9] Re-enable and write resumes remaining data
// [R10] Halt stops transfer at once, mid byte
// [R11] Software keeps mode while active flag set
// [R12] Interrupt at tenth clock master, eighth slave
// [R13] Buffer access after eighth rising edge
// [R14] Select clear: gap is two clock periods
// [R15] Select set: gap is larger of both
// [R16] Software picks interval covering buffer access
// [R17] Non-repeat ends after byte at pointer zero
// [R18] Data output low while not active
// [R19] Repeat mode cycles until enable cleared
`timescale 1ns/10ps
module abx_top #(
   parameter int BUF_DEPTH = 32,
   parameter int HALF      = abx_pkg::SCK_HALF_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        cpu_halt,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   output logic             so_o,
   output logic             so_oe,
   input  wire logic        si_i,
   output logic             si_en,
   output logic             irq
);
   localparam int PW = $clog2(BUF_DEPTH);

   abx_shift_if sif ();
   abx_pkg::abx_state_type st_r;
   logic          dp_wr_r;
   logic [11:0]   dp_addr_r;
   logic          en_r;
   logic          slv_r;
   logic          re_r;
   logic          rld_r;
   logic          sel_r;
   logic [4:0]    ival_r;
   logic [PW-1:0] ptr_r;
   logic [PW-1:0] start_r;
   logic          act_r;
   logic          susp_r;
   logic [1:0]    sts_r;
   logic [1:0]    msk_r;
   logic [5:0]    gcnt_r;
   logic [7:0]    mem [BUF_DEPTH];
   logic          ck1_r;
   logic          ck2_r;
   logic          ck3_r;
   logic          si1_r;
   logic          si2_r;
   logic          half;
   logic          ap;
   logic          trig;
   logic          ext_rise;
   logic          ext_fall;
   logic          tick;
   logic          last;
   logic          rpt;
   logic          gdone;
   logic          end_set;
   logic          hlt_set;
   logic [4:0]    gper;
   logic [5:0]    tgt;
   logic [31:0]   rd_data;

   // Buffer window decode
   function automatic logic in_buf(input logic [11:0] a);
      return (a >= abx_pkg::A_BUF) && (a < abx_pkg::A_BUF + 12'(4 * BUF_DEPTH));
   endfunction

   function automatic logic [PW-1:0] buf_idx(input logic [11:0] a);
      return a[PW+1:2];
   endfunction

   // Bus address phase qualifier and write trigger
   assign ap   = hsel && hready && htrans[1] && (hsize == 3'b010);
   assign trig = dp_wr_r && (dp_addr_r == abx_pkg::A_SHIFT);

   // Bus data phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r   <= 1'b0;
         dp_addr_r <= 12'h000;
      end else begin
         dp_wr_r   <= ap && hwrite;
         dp_addr_r <= haddr[11:0];
      end
   end

   // Register read view
   always_comb begin
      rd_data = 32'h0000_0000;
      case (haddr[11:0])
         abx_pkg::A_MODE: begin
            rd_data[abx_pkg::MODE_EN_BIT]  = en_r;
            rd_data[abx_pkg::MODE_SLV_BIT] = slv_r;
         end
         abx_pkg::A_AXC: begin
            rd_data[abx_pkg::AXC_RE_BIT]  = re_r;
            rd_data[abx_pkg::AXC_RLD_BIT] = rld_r;
            rd_data[abx_pkg::AXC_TRF_BIT] = act_r;
         end
         abx_pkg::A_IVL: begin
            rd_data[abx_pkg::IVL_SEL_BIT] = sel_r;
            rd_data[4:0]                  = ival_r;
         end
         abx_pkg::A_PTR:   rd_data[PW-1:0] = ptr_r;
         abx_pkg::A_SHIFT: rd_data[7:0] = sif.rx;
         abx_pkg::A_STS:   rd_data[1:0] = sts_r;
         abx_pkg::A_MSK:   rd_data[1:0] = msk_r;
         default: begin
            if (in_buf(haddr[11:0])) begin
               rd_data[7:0] = mem[buf_idx(haddr[11:0])];
            end
         end
      endcase
   end

   // Bus answer, zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (ap && !hwrite) begin
            hrdata <= rd_data;
         end
      end
   end

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r   <= 1'b0;
         slv_r  <= 1'b0;
         re_r   <= 1'b0;
         rld_r  <= 1'b0;
         sel_r  <= 1'b0;
         ival_r <= abx_pkg::RST_IVL;
         msk_r  <= 2'h0;
      end else if (dp_wr_r) begin
         case (dp_addr_r)
            abx_pkg::A_MODE: begin
               en_r  <= hwdata[abx_pkg::MODE_EN_BIT];
               slv_r <= hwdata[abx_pkg::MODE_SLV_BIT];
            end
            abx_pkg::A_AXC: begin
               re_r  <= hwdata[abx_pkg::AXC_RE_BIT];
               rld_r <= hwdata[abx_pkg::AXC_RLD_BIT];
            end
            abx_pkg::A_IVL: begin
               sel_r  <= hwdata[abx_pkg::IVL_SEL_BIT];
               ival_r <= hwdata[4:0];
            end
            abx_pkg::A_MSK: msk_r <= hwdata[1:0];
            default: ;
         endcase
      end
   end

   // Pin synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck1_r <= 1'b1;
         ck2_r <= 1'b1;
         ck3_r <= 1'b1;
         si1_r <= 1'b0;
         si2_r <= 1'b0;
      end else begin
         ck1_r <= sck_i;
         ck2_r <= ck1_r;
         ck3_r <= ck2_r;
         si1_r <= si_i;
         si2_r <= si1_r;
      end
   end

   assign ext_rise = ck2_r && !ck3_r;
   assign ext_fall = !ck2_r && ck3_r;

   abx_clkdiv #(
      .HALF (HALF)
   ) u_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     ((st_r != abx_pkg::S_IDLE) && !slv_r),
      .half    (half)
   );

   // Shifter controls, first byte comes from buffer not trigger
   assign sif.load  = (st_r == abx_pkg::S_LOAD); // [R4]
   assign sif.din   = mem[ptr_r];
   assign sif.abort = cpu_halt; // [R10]
   assign sif.si    = si2_r;
   assign sif.rise  = (st_r == abx_pkg::S_SHIFT) && (slv_r ? ext_rise : (half && !sck_o));
   assign sif.fall  = (st_r == abx_pkg::S_SHIFT) && (slv_r ? ext_fall : (half && sck_o));

   abx_shifter u_shf (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sif     (sif)
   );

   // Gap length in clock periods, halves counted in master
   assign gper  = (sel_r && ival_r > abx_pkg::MIN_GAP_PER) ? ival_r : abx_pkg::MIN_GAP_PER; // [R14] [R15]
   assign tgt   = (st_r == abx_pkg::S_TAIL) ? (slv_r ? {1'b0, abx_pkg::TAIL_PER} : {abx_pkg::TAIL_PER, 1'b0})
                                            : (slv_r ? {1'b0, gper} : {gper, 1'b0});
   assign tick  = slv_r ? ext_rise : half;
   assign gdone = tick && (gcnt_r + 6'h01 >= tgt);
   assign last  = (ptr_r == '0);
   assign rpt   = rld_r && !re_r; // [R3]
   assign end_set = (st_r == abx_pkg::S_SHIFT && sif.done && last && !rpt && slv_r)
                 || (st_r == abx_pkg::S_TAIL && gdone); // [R12]
   assign hlt_set = cpu_halt && act_r;

   // Transfer sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r    <= abx_pkg::S_IDLE;
         ptr_r   <= '0;
         start_r <= '0;
         act_r   <= 1'b0;
         susp_r  <= 1'b0;
         gcnt_r  <= 6'h00;
      end else if (hlt_set) begin
         st_r   <= abx_pkg::S_IDLE; // [R10]
         act_r  <= 1'b0;
         susp_r <= 1'b1;
      end else begin
         case (st_r)
            abx_pkg::S_IDLE: begin
               if (dp_wr_r && dp_addr_r == abx_pkg::A_PTR) begin
                  ptr_r  <= hwdata[PW-1:0];
                  susp_r <= 1'b0; // New pointer is a fresh start, no stale reload value
               end else if (trig && en_r) begin // [R1] [R9]
                  if (!susp_r) begin
                     start_r <= ptr_r;
                  end
                  susp_r <= 1'b0;
                  act_r  <= 1'b1;
                  st_r   <= abx_pkg::S_LOAD;
               end
            end
            abx_pkg::S_LOAD: begin
               st_r <= abx_pkg::S_SHIFT;
            end
            abx_pkg::S_SHIFT: begin
               gcnt_r <= 6'h00;
               if (sif.done) begin // [R13]
                  if (last && !rpt) begin
                     act_r <= 1'b0; // [R17]
                     st_r  <= slv_r ? abx_pkg::S_IDLE : abx_pkg::S_TAIL;
                  end else begin
                     if (last) begin
                        ptr_r <= start_r; // [R2] [R3] [R19]
                     end else begin
                        ptr_r <= ptr_r - 1'b1; // [R5]
                     end
                     if (!en_r) begin
                        act_r  <= 1'b0; // [R7] [R8]
                        susp_r <= 1'b1;
                        st_r   <= abx_pkg::S_IDLE;
                     end else begin
                        st_r <= abx_pkg::S_GAP;
                     end
                  end
               end
            end
            abx_pkg::S_GAP, abx_pkg::S_TAIL: begin
               if (gdone) begin
                  gcnt_r <= 6'h00;
                  st_r   <= (st_r == abx_pkg::S_GAP) ? abx_pkg::S_LOAD : abx_pkg::S_IDLE;
               end else if (tick) begin
                  gcnt_r <= gcnt_r + 6'h01;
               end
            end
            default: st_r <= abx_pkg::S_IDLE;
         endcase
      end
   end

   // Buffer memory, received byte stored at pointer after the byte
   always_ff @(posedge hclk) begin
      if (st_r == abx_pkg::S_SHIFT && sif.done && re_r) begin
         mem[ptr_r] <= sif.rx; // [R13]
      end else if (dp_wr_r && in_buf(dp_addr_r)) begin
         mem[buf_idx(dp_addr_r)] <= hwdata[7:0];
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sts_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (dp_wr_r && dp_addr_r == abx_pkg::A_STS && hwdata[i]) begin
               sts_r[i] <= 1'b0;
            end
         end
         if (end_set) begin
            sts_r[abx_pkg::STS_END_BIT] <= 1'b1; // [R12]
         end
         if (hlt_set) begin
            sts_r[abx_pkg::STS_HLT_BIT] <= 1'b1;
         end
      end
   end

   // Serial clock output, idles high, toggles while shifting in master mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_o <= 1'b1;
      end else if (cpu_halt || slv_r || st_r != abx_pkg::S_SHIFT) begin
         sck_o <= 1'b1;
      end else if (half) begin
         sck_o <= ~sck_o;
      end
   end

   // Pin functions and interrupt line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_oe <= 1'b0;
         so_o   <= 1'b0;
         so_oe  <= 1'b0;
         si_en  <= 1'b0;
         irq    <= 1'b0;
      end else begin
         sck_oe <= (act_r || st_r == abx_pkg::S_TAIL) && !slv_r; // [R8]
         so_o   <= act_r ? sif.so : 1'b0; // [R18]
         so_oe  <= act_r; // [R8]
         si_en  <= act_r && re_r; // [R6]
         irq    <= |(sts_r & msk_r);
      end
   end
endmodule

//--- verification/abx_properties.sv
`timescale 1ns/10ps
module abx_checker #(
   parameter int HALF = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cpu_halt,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic so_o,
   input wire logic so_oe,
   input wire logic si_en,
   input wire logic irq
);
   int lo_cnt;
   int hi_cnt;
   // Run lengths of the serial clock, low anywhere and high within a frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lo_cnt <= 0;
         hi_cnt <= 0;
      end else begin
         lo_cnt <= sck_o ? 0 : lo_cnt + 1;
         hi_cnt <= (sck_o && so_oe) ? hi_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_so_idle_low: assert property (!so_oe |-> !so_o)
      else $error("data out high while idle");
   a_sck_idle_high: assert property (!sck_oe |-> sck_o)
      else $error("serial clock low while released");
   a_si_port_free: assert property (si_en |-> so_oe)
      else $error("data in taken outside a transfer");
   a_halt_abort: assert property ($rose(cpu_halt) && so_oe |-> ##[1:2] !so_oe)
      else $error("halt did not stop the transfer");
   a_sck_low_time: assert property ($rose(sck_o) && sck_oe && !cpu_halt && !$past(cpu_halt) |-> lo_cnt == HALF)
      else $error("serial clock low phase has wrong length");
   a_gap_minimum: assert property ($fell(sck_o) && hi_cnt > 2 * HALF |-> hi_cnt >= 4 * HALF)
      else $error("gap between bytes too short");
   a_tail_irq: assert property ($fell(so_oe) && sck_oe && !cpu_halt && !irq |-> !irq [*8])
      else $error("interrupt before the trailing clocks");
endmodule
bind abx_top abx_checker #(.HALF(HALF)) i_abx_checker (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .cpu_halt(cpu_halt), .sck_o(sck_o), .sck_oe(sck_oe), .so_o(so_o), .so_oe(so_oe),
   .si_en(si_en), .irq(irq));

//--- verification/abx_partner.sv
`timescale 1ns/10ps
module abx_partner #(
   parameter logic [7:0] REPLY = 8'h5a
) (
   input  wire logic  hclk,
   input  wire logic  slave,
   input  wire logic  sck_o,
   input  wire logic  so_o,
   input  wire logic  so_oe,
   output logic       sck_i,
   output logic       si_i,
   output logic       got,
   output logic [7:0] data
);
   logic       clk_d = 1'b1;
   logic [2:0] bits = 3'h0;
   logic [7:0] sh = 8'h00;
   logic       clk_seen;
   assign clk_seen = slave ? sck_i : sck_o;
   // Takes data out on rising edges, puts the reply out on falling edges
   initial begin
      got = 1'b0;
      si_i = 1'b0;
      data = 8'h00;
      forever begin
         @(posedge hclk);
         got <= 1'b0;
         clk_d <= clk_seen;
         if (!so_oe) begin
            bits <= 3'h0;
            si_i <= ~si_i; // Released line never holds its last value
         end else if (clk_d && !clk_seen) begin
            si_i <= REPLY[3'h7 - bits];
         end else if (!clk_d && clk_seen) begin
            sh <= {sh[6:0], so_o};
            bits <= bits + 3'h1;
            got <= (bits == 3'h7);
            data <= {sh[6:0], so_o};
         end
      end
   end
   // Slave clock: bursts of eight periods in a frame, still between them
   initial begin
      sck_i = 1'b1;
      forever begin
         @(posedge hclk);
         if (slave && so_oe) begin
            repeat (4) @(posedge hclk);
            #7;
            repeat (16) #80 sck_i = ~sck_i;
            repeat (50) @(posedge hclk);
         end
      end
   end
endmodule

//--- verification/auto_buffer_serial_repeat_xfer_test.sv
`timescale 1ns/10ps
module auto_buffer_serial_repeat_xfer_test;
   localparam int         HALF = 4;
   localparam logic [7:0] REPLY = 8'h5a;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        cpu_halt = 1'b0;
   logic        slave = 1'b0;
   logic        rd_on = 1'b0;
   logic        hready, hreadyout, hresp, sck_i, sck_o, sck_oe, so_o, so_oe, si_i, si_en, irq, got;
   logic [31:0] hrdata;
   logic [7:0]  data;
   logic [7:0]  mem[4];
   logic [31:0] exp_rd[$];
   logic [31:0] exp_tx[$];
   int          num_errors = 0;
   int          num_checks = 0;
   int          n_bytes = 0;
   int          hi_run = 0;
   int          gap_len = 0;
   int          base, i, k;
   int          seed = 32'h2e6b;
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   abx_top #(.HALF(HALF)) i_abx_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_halt(cpu_halt), .sck_i(sck_i),
      .sck_o(sck_o), .sck_oe(sck_oe), .so_o(so_o), .so_oe(so_oe), .si_i(si_i), .si_en(si_en), .irq(irq));
   abx_partner #(.REPLY(REPLY)) i_abx_partner (.hclk(hclk), .slave(slave), .sck_o(sck_o), .so_o(so_o),
      .so_oe(so_oe), .sck_i(sck_i), .si_i(si_i), .got(got), .data(data));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return irq;
         1: return so_oe;
         2: return sck_o;
         default: return n_bytes >= k;
      endcase
   endfunction
   // Bounded wait for a level; running out ends the run
   task automatic wait_for(input int w, input logic v);
      int n;
      for (n = 0; n < 20000 && sig(w) !== v; n++)
         @(posedge hclk);
      if (sig(w) !== v) begin
         num_errors++;
         give_verdict();
      end
   endtask
   task automatic wait_rdy;
      int n;
      @(posedge hclk);
      for (n = 0; n < 50 && hreadyout !== 1'b1; n++)
         @(posedge hclk);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
   endtask
   // One single word transfer, then an idle cycle
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rd_on <= !w;
      wait_rdy();
      rd_on <= 1'b0;
      hsel <= 1'b0;
      @(posedge hclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask
   // Plain transfer from pointer p down to zero, ended by its status
   task automatic run(input int p, input logic [31:0] sts);
      int j;
      wr(abx_pkg::A_PTR, 32'(p));
      for (j = p; j >= 0; j--)
         exp_tx.push_back({24'h0, mem[j]});
      wr(abx_pkg::A_SHIFT, $random(seed));
      wait_for(0, 1'b1);
      rd(abx_pkg::A_STS, sts);
      wr(abx_pkg::A_STS, sts);
   endtask
   // Compares each answer with the oldest note, and measures gaps
   always @(posedge hclk) begin
      hi_run <= (sck_o && so_oe) ? hi_run + 1 : 0;
      if (so_oe && !sck_o && hi_run > 2 * HALF)
         gap_len <= hi_run;
      if (rd_on && hreadyout)
         check(hrdata, exp_rd.size() ? exp_rd.pop_front() : 'x);
      if (got) begin
         n_bytes <= n_bytes + 1;
         check({24'h0, data}, exp_tx.size() ? exp_tx.pop_front() : 'x);
      end
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 8; i++)
         rd(12'(4 * i), 32'h0);
      for (i = 0; i < 4; i++) begin
         mem[i] = 8'($random(seed));
         wr(abx_pkg::A_BUF + 12'(4 * i), {24'h0, mem[i]});
      end
      wr(abx_pkg::A_MSK, 32'h3);
      wr(abx_pkg::A_MODE, 32'h80);
      run(2, 32'h1);
      base = gap_len;
      // Interval select: below two periods changes nothing, above adds
      for (i = 0; i < 2; i++) begin
         wr(abx_pkg::A_IVL, i ? 32'h85 : 32'h81);
         run(1, 32'h1);
         check(32'(gap_len - base), i ? 32'(6 * HALF) : 32'h0);
      end
      wr(abx_pkg::A_IVL, 32'h0);
      // Repeat mode, then enable cleared in mid byte and restarted by a new pointer write
      wr(abx_pkg::A_AXC, 32'h40);
      wr(abx_pkg::A_PTR, 32'h1);
      for (i = 0; i < 5; i++)
         exp_tx.push_back({24'h0, mem[1 - i % 2]});
      k = n_bytes + 4;
      wr(abx_pkg::A_SHIFT, $random(seed));
      wait_for(3, 1'b1);
      wait_for(2, 1'b0);
      wr(abx_pkg::A_MODE, 32'h0);
      wait_for(1, 1'b0);
      rd(abx_pkg::A_AXC, 32'h40);
      rd(abx_pkg::A_STS, 32'h0);
      rd(abx_pkg::A_PTR, 32'h0);
      wr(abx_pkg::A_AXC, 32'h0);
      wr(abx_pkg::A_MODE, 32'h80);
      run(0, 32'h1);
      // Halt in mid byte with its status masked, then unmasked and cleared
      wr(abx_pkg::A_MSK, 32'h1);
      wr(abx_pkg::A_PTR, 32'h3);
      exp_tx.push_back({24'h0, mem[3]});
      k = n_bytes + 1;
      wr(abx_pkg::A_SHIFT, $random(seed));
      wait_for(3, 1'b1);
      wait_for(2, 1'b0);
      check({31'h0, si_en}, 32'h0);
      cpu_halt <= 1'b1;
      wait_for(1, 1'b0);
      cpu_halt <= 1'b0;
      rd(abx_pkg::A_STS, 32'h2);
      rd(abx_pkg::A_PTR, 32'h2);
      check({31'h0, irq}, 32'h0);
      wr(abx_pkg::A_MSK, 32'h3);
      wait_for(0, 1'b1);
      wr(abx_pkg::A_STS, 32'h2);
      wait_for(0, 1'b0);
      // Transmit and receive with reload set: no repeat, replies land in the buffer
      wr(abx_pkg::A_AXC, 32'hc0);
      run(1, 32'h1);
      rd(abx_pkg::A_BUF + 12'h4, {24'h0, REPLY});
      rd(abx_pkg::A_BUF, {24'h0, REPLY});
      rd(abx_pkg::A_SHIFT, {24'h0, REPLY});
      mem[0] = REPLY;
      wr(abx_pkg::A_AXC, 32'h0);
      // Slave mode on the outside clock
      slave <= 1'b1;
      wr(abx_pkg::A_MODE, 32'h81);
      run(0, 32'h1);
      check(32'(exp_tx.size() + exp_rd.size()), 32'h0);
      give_verdict();
   end
endmodule
